// ### verilog/nvm_access.v
// memory access and protection: sram arbitration, flash row fetch with
// secded ecc and instruction buffer, per-block protection, eeprom path,
// nonvolatile config latches applied at reset.
// assumes flash, eeprom arrays and programmer sit outside on ref_clk.
// Operation
// - cpu and dma share sram only across blocks
// - correct single, detect double error per row
// - pulse interrupt request on ecc error
// - flash read fetches whole nine byte row
// - row data loads eight byte instruction buffer
// - no code fetch from ecc region
// - latch bit selects ecc use of region
// - programming stalls code fetches from flash
// - blocks hold 256 data, 32 ecc bytes
// - per block protection level of four
// - protection changes only during full erase
// - factory level blocks external reads only
// - field level blocks all external access
// - full level permits internal reads only
// - eeprom read direct, writes by command
// - eeprom writes do not stall fetches
// - eeprom 128 rows of 16 bytes
// - no ecc, no execution from eeprom
// - four config latch bytes applied at reset
// - port drive mode applies to all pins
// - latch bit selects reset pin use
// - latch field selects debug port
`timescale 1ns/1ps
`include "nvm_consts.vh"
module nvm_access (
   // clock, reset and latch array power-on clear
   input wire ref_clk,
   input wire rstn,
   input wire porClearN,
   // config latch register port
   input wire [1:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWrStb,
   input wire regRdStb,
   output reg [7:0] regRdData_r,
   // sram requests
   input wire cpuSramReq,
   input wire [12:0] cpuSramAddr,
   input wire dmaSramReq,
   input wire [12:0] dmaSramAddr,
   output wire cpuSramGnt,
   output wire dmaSramGnt,
   // cpu code fetch
   input wire fetchReq,
   input wire [1:0] fetchTarget,
   input wire [15:0] fetchAddr,
   output reg fetchRdy_r,
   output reg [7:0] fetchData_r,
   output reg fetchFault_r,
   // flash row port
   output reg rowRdReq_r,
   output reg [12:0] rowRdAddr_r,
   input wire rowValid,
   input wire [71:0] rowData,
   output reg eccIrq_r,
   output reg eccDouble_r,
   // flash programming interface
   input wire progActive,
   input wire eraseAllActive,
   input wire protWrStb,
   input wire [7:0] protWrBlock,
   input wire [1:0] protWrLevel,
   output reg protReject_r,
   // protection check
   input wire accExternal,
   input wire accWrite,
   input wire [7:0] accBlock,
   output wire accAllow,
   // eeprom path
   input wire eeRdStb,
   input wire [10:0] eeRdAddr,
   output wire [10:0] eeMemAddr,
   input wire [7:0] eeMemData,
   output reg [7:0] eeRdData_r,
   output reg eeRdValid_r,
   input wire eeStoreStb,
   output reg eeStoreFault_r,
   input wire eeCmdStb,
   input wire eeCmdErase,
   input wire [10:0] eeCmdAddr,
   input wire eeBusy,
   output reg eeRowStb_r,
   output reg eeRowErase_r,
   output reg [6:0] eeRowIdx_r,
   output reg eeCmdReject_r,
   // applied configuration
   output wire [143:0] pinResetDrive,
   output wire resetPinIsExt,
   output wire jtag5En,
   output wire jtag4En,
   output wire swdEn,
   output wire eccRegionEn,
   output wire [3:0] clkPhaseDelay
);

   localparam ST_IDLE = 1'b0;
   localparam ST_WAIT = 1'b1;

   reg [7:0] latch_r [0:3];
   reg [7:0] cfg_r [0:3];
   reg [1:0] prot_r [0:`NVM_PROT_BLOCKS-1];
   reg [7:0] buf_r [0:7];
   reg [12:0] bufTag_r;
   reg bufValid_r;
   reg state_r;
   reg sramPri_r;
   reg eraseSeen_r;
   reg [7:0] wrMask;
   wire [63:0] rowWord;
   wire [7:0] rowCheck;
   wire [7:0] calcCheck;
   wire [6:0] syn;
   wire parErr;
   wire sglErr;
   wire dblErr;
   wire [63:0] fixWord;
   wire [63:0] useWord;
   wire progBusy;
   wire hit;
   wire fetchMain;
   wire [17:0] portMode;
   wire [1:0] lvl;
   wire [1:0] dbgSel;
   integer k;
   integer kp;
   integer kc;

   // hamming check bits over data positions, plus overall parity on top
   function [7:0] eccGen;
      input [63:0] d;
      integer i;
      integer p;
      reg [6:0] s;
      begin
         s = 7'h00;
         p = `NVM_ECC_POS0;
         for (i = 0; i < 64; i = i + 1) begin
            if (d[i]) begin
               s = s ^ p[6:0];
            end
            p = p + 1;
            if ((p & (p - 1)) == 0) begin
               p = p + 1;
            end
         end
         eccGen = {^{d, s}, s};
      end
   endfunction

   // flip the data bit whose codeword position equals the syndrome
   function [63:0] eccFix;
      input [63:0] d;
      input [6:0] s;
      integer i;
      integer p;
      begin
         eccFix = d;
         p = `NVM_ECC_POS0;
         for (i = 0; i < 64; i = i + 1) begin
            if (p[6:0] == s) begin
               eccFix[i] = ~d[i];
            end
            p = p + 1;
            if ((p & (p - 1)) == 0) begin
               p = p + 1;
            end
         end
      end
   endfunction

   assign rowWord = rowData[63:0];
   assign rowCheck = rowData[71:64];

   assign calcCheck = eccGen(rowWord);
   assign syn = calcCheck[6:0] ^ rowCheck[6:0];
   assign parErr = ^{rowWord, rowCheck};
   assign sglErr = parErr;
   assign dblErr = ~parErr & (syn != 7'h00);
   assign fixWord = eccFix(rowWord, syn);

   // ecc byte ignored when region holds data
   assign useWord = (eccRegionEn && sglErr) ? fixWord : rowWord;

   // eeBusy deliberately not part of the stall
   assign progBusy = progActive | eraseAllActive;
   assign hit = bufValid_r && (bufTag_r == fetchAddr[15:3]);
   assign fetchMain = (fetchTarget == `NVM_TGT_MAIN);

   // same block conflict serialized by rotating priority
   assign cpuSramGnt = cpuSramReq & (~dmaSramReq | ~sramPri_r |
      (cpuSramAddr[`NVM_SRAM_BLK] != dmaSramAddr[`NVM_SRAM_BLK]));
   assign dmaSramGnt = dmaSramReq & (~cpuSramReq | sramPri_r |
      (cpuSramAddr[`NVM_SRAM_BLK] != dmaSramAddr[`NVM_SRAM_BLK]));

   // priority flips only after a conflict so neither side starves
   always @(posedge ref_clk) begin
      if (!rstn) begin
         sramPri_r <= 1'b0;
      end else if (cpuSramReq && dmaSramReq && (cpuSramAddr[`NVM_SRAM_BLK] ==
            dmaSramAddr[`NVM_SRAM_BLK])) begin
         sramPri_r <= ~sramPri_r;
      end
   end

   // fetch path: serve from buffer on hit, otherwise read one row
   always @(posedge ref_clk) begin
      if (!rstn) begin
         state_r <= ST_IDLE;
         bufValid_r <= 1'b0;
         bufTag_r <= 13'h0000;
         fetchRdy_r <= 1'b0;
         fetchData_r <= 8'h00;
         fetchFault_r <= 1'b0;
         rowRdReq_r <= 1'b0;
         rowRdAddr_r <= 13'h0000;
         eccIrq_r <= 1'b0;
         eccDouble_r <= 1'b0;
         for (k = 0; k < 8; k = k + 1) begin
            buf_r[k] <= 8'h00;
         end
      end else begin
         fetchRdy_r <= 1'b0;
         fetchFault_r <= 1'b0;
         rowRdReq_r <= 1'b0;
         eccIrq_r <= 1'b0;
         eccDouble_r <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (progBusy) begin
                  bufValid_r <= 1'b0;
               end else if (fetchReq && !fetchRdy_r && !fetchFault_r) begin
                  if (!fetchMain) begin
                     fetchFault_r <= 1'b1;
                  end else if (hit) begin
                     fetchRdy_r <= 1'b1;
                     fetchData_r <= buf_r[fetchAddr[2:0]];
                  end else begin
                     rowRdReq_r <= 1'b1;
                     rowRdAddr_r <= fetchAddr[15:3];
                     state_r <= ST_WAIT;
                  end
               end
            end
            ST_WAIT: begin
               if (rowValid) begin
                  state_r <= ST_IDLE;
                  eccIrq_r <= eccRegionEn & (sglErr | dblErr);
                  eccDouble_r <= eccRegionEn & dblErr;
                  if (eccRegionEn && dblErr) begin
                     bufValid_r <= 1'b0;
                     fetchFault_r <= 1'b1;
                  end else begin
                     bufValid_r <= 1'b1;
                     bufTag_r <= rowRdAddr_r;
                     for (k = 0; k < 8; k = k + 1) begin
                        buf_r[k] <= useWord[k*8 +: 8];
                     end
                  end
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // protection table per 256 byte block, nonvolatile like the latches
   always @(posedge ref_clk) begin
      if (!porClearN) begin
         eraseSeen_r <= 1'b0;
         protReject_r <= 1'b0;
         for (kp = 0; kp < `NVM_PROT_BLOCKS; kp = kp + 1) begin
            prot_r[kp] <= `NVM_PL_OPEN;
         end
      end else begin
         eraseSeen_r <= eraseAllActive;
         protReject_r <= 1'b0;
         if (eraseAllActive && !eraseSeen_r) begin
            // full erase reopens every block
            // a level written in the clearing cycle would be lost, so refuse it
            protReject_r <= protWrStb;
            for (kp = 0; kp < `NVM_PROT_BLOCKS; kp = kp + 1) begin
               prot_r[kp] <= `NVM_PL_OPEN;
            end
         end else if (protWrStb && eraseAllActive) begin
            prot_r[protWrBlock] <= protWrLevel;
         end else if (protWrStb) begin
            protReject_r <= 1'b1;
         end
      end
   end

   // block index is address bits 15:8
   assign lvl = prot_r[accBlock];
   assign accAllow = (lvl == `NVM_PL_OPEN) ||
      (lvl == `NVM_PL_FACT && !(accExternal && !accWrite)) ||
      (lvl == `NVM_PL_FIELD && !accExternal) ||
      (lvl == `NVM_PL_FULL && !accExternal && !accWrite);

   assign eeMemAddr = eeRdAddr;

   // eeprom reads return next cycle; row commands go to the programmer
   always @(posedge ref_clk) begin
      if (!rstn) begin
         eeRdData_r <= 8'h00;
         eeRdValid_r <= 1'b0;
         eeStoreFault_r <= 1'b0;
         eeRowStb_r <= 1'b0;
         eeRowErase_r <= 1'b0;
         eeRowIdx_r <= 7'h00;
         eeCmdReject_r <= 1'b0;
      end else begin
         eeRdValid_r <= eeRdStb;
         eeRdData_r <= eeRdStb ? eeMemData : 8'h00;
         eeStoreFault_r <= eeStoreStb;
         eeRowStb_r <= eeCmdStb & ~eeBusy;
         eeCmdReject_r <= eeCmdStb & eeBusy;
         if (eeCmdStb && !eeBusy) begin
            eeRowIdx_r <= eeCmdAddr[`NVM_EE_ROW_HI:`NVM_EE_ROW_LO];
            eeRowErase_r <= eeCmdErase;
         end
      end
   end

   // write masks keep reserved bits at zero
   always @* begin
      wrMask = `NVM_MASK0;
      if (regAddr == `NVM_REG_DRV_HI) begin
         wrMask = `NVM_MASK1;
      end else if (regAddr == `NVM_REG_PIN_DRV) begin
         wrMask = `NVM_MASK2;
      end else if (regAddr == `NVM_REG_DBG_ECC) begin
         wrMask = `NVM_MASK3;
      end
   end

   // latch array: survives rstn, cleared to defaults only at power-on
   always @(posedge ref_clk) begin
      if (!porClearN) begin
         latch_r[`NVM_REG_DRV_LO] <= `NVM_DEF0;
         latch_r[`NVM_REG_DRV_HI] <= `NVM_DEF1;
         latch_r[`NVM_REG_PIN_DRV] <= `NVM_DEF2;
         latch_r[`NVM_REG_DBG_ECC] <= `NVM_DEF3;
      end else if (regWrStb) begin
         latch_r[regAddr] <= regWrData & wrMask;
      end
   end

   // register read data valid only in the cycle after the strobe
   always @(posedge ref_clk) begin
      if (!rstn) begin
         regRdData_r <= 8'h00;
      end else begin
         regRdData_r <= regRdStb ? latch_r[regAddr] : 8'h00;
      end
   end

   // latches copied while reset held; writes apply next reset
   always @(posedge ref_clk) begin
      if (!rstn) begin
         for (kc = 0; kc < 4; kc = kc + 1) begin
            cfg_r[kc] <= latch_r[kc];
         end
      end
   end

   // port fields in order 0..6, 12, 15
   assign portMode = {cfg_r[`NVM_REG_PIN_DRV][`NVM_P15_HI:`NVM_P15_LO],
      cfg_r[`NVM_REG_DRV_HI], cfg_r[`NVM_REG_DRV_LO]};

   // each pin copies its port field
   genvar g;
   generate
      for (g = 0; g < 72; g = g + 1) begin : pinMap
         assign pinResetDrive[2*g+1:2*g] = portMode[2*(g/8)+1:2*(g/8)];
      end
   endgenerate

   assign resetPinIsExt = cfg_r[`NVM_REG_PIN_DRV][`NVM_XRES_BIT];
   // debug port decode; other code disables all
   assign dbgSel = cfg_r[`NVM_REG_DBG_ECC][`NVM_DPS_HI:`NVM_DPS_LO];
   assign jtag5En = (dbgSel == `NVM_DBG_JTAG5);
   assign jtag4En = (dbgSel == `NVM_DBG_JTAG4);
   assign swdEn = (dbgSel == `NVM_DBG_SWD);
   assign eccRegionEn = cfg_r[`NVM_REG_DBG_ECC][`NVM_ECC_REGION_ENABLE_BIT];
   // raw phase delay to clock logic
   assign clkPhaseDelay = cfg_r[`NVM_REG_DBG_ECC][`NVM_PHS_HI:`NVM_PHS_LO];

endmodule

// ### verilog/nvm_consts.vh
// constants for the on-chip memory access and protection block
// assumes inclusion by bare name from the design file
`ifndef NVM_CONSTS_VH
`define NVM_CONSTS_VH
// config latch byte indices
`define NVM_REG_DRV_LO 2'h0
`define NVM_REG_DRV_HI 2'h1
`define NVM_REG_PIN_DRV 2'h2
`define NVM_REG_DBG_ECC 2'h3
// config latch factory defaults
`define NVM_DEF0 8'h00
`define NVM_DEF1 8'h00
`define NVM_DEF2 8'h00
`define NVM_DEF3 8'h01
// writable bits per byte; reserved bits read zero
`define NVM_MASK0 8'hff
`define NVM_MASK1 8'hff
`define NVM_MASK2 8'h83
`define NVM_MASK3 8'hfb
// field positions
`define NVM_XRES_BIT 7
`define NVM_P15_HI 1
`define NVM_P15_LO 0
`define NVM_PHS_HI 7
`define NVM_PHS_LO 4
`define NVM_ECC_REGION_ENABLE_BIT 3
`define NVM_DPS_HI 1
`define NVM_DPS_LO 0
// debug port select encodings
`define NVM_DBG_JTAG5 2'h0
`define NVM_DBG_JTAG4 2'h1
`define NVM_DBG_SWD 2'h2
// protection levels
`define NVM_PL_OPEN 2'h0
`define NVM_PL_FACT 2'h1
`define NVM_PL_FIELD 2'h2
`define NVM_PL_FULL 2'h3
// fetch targets
`define NVM_TGT_MAIN 2'h0
// sram block select bit (4 KB blocks)
`define NVM_SRAM_BLK 12
// flash: 256 blocks of 256 data bytes
`define NVM_PROT_BLOCKS 256
// eeprom: 128 rows of 16 bytes
`define NVM_EE_ROW_HI 10
`define NVM_EE_ROW_LO 4
// ecc: first non-power-of-two codeword position
`define NVM_ECC_POS0 3
`endif

// ### tb/nvm_access_props.sv
// checker for the memory access block, watching top level ports only
// assumes one clock domain, reset synchronous and active low
`timescale 1ns/1ps
module nvm_access_chk (
   // clock and reset
   input wire ref_clk,
   input wire rstn,
   // sram arbitration
   input wire cpuSramReq,
   input wire [12:0] cpuSramAddr,
   input wire dmaSramReq,
   input wire [12:0] dmaSramAddr,
   input wire cpuSramGnt,
   input wire dmaSramGnt,
   // fetch and flash row
   input wire fetchReq,
   input wire [1:0] fetchTarget,
   input wire [15:0] fetchAddr,
   input wire fetchRdy_r,
   input wire fetchFault_r,
   input wire rowRdReq_r,
   input wire [12:0] rowRdAddr_r,
   input wire eccIrq_r,
   input wire eccDouble_r,
   input wire eccRegionEn,
   // programming and protection
   input wire progActive,
   input wire eraseAllActive,
   input wire protWrStb,
   input wire protReject_r,
   // eeprom
   input wire eeRdStb,
   input wire [7:0] eeMemData,
   input wire [7:0] eeRdData_r,
   input wire eeRdValid_r,
   input wire eeStoreStb,
   input wire eeStoreFault_r,
   input wire eeCmdStb,
   input wire [10:0] eeCmdAddr,
   input wire eeBusy,
   input wire eeRowStb_r,
   input wire [6:0] eeRowIdx_r
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   // eeprom command steps: accepted request, then the row pulse
   sequence eeCmdGo;
      eeCmdStb && !eeBusy;
   endsequence
   sequence eeRowOut;
      eeRowStb_r && eeRowIdx_r == ($past(eeCmdAddr) >> 4);
   endsequence
   sram_share_a: assert property (
      cpuSramGnt && dmaSramGnt |-> cpuSramAddr[12] != dmaSramAddr[12]) else $error("sram share");
   sram_serve_a: assert property (
      cpuSramReq && dmaSramReq |-> cpuSramGnt || dmaSramGnt) else $error("sram starved");
   fetch_stall_a: assert property (
      fetchRdy_r |-> !$past(progActive) && !$past(eraseAllActive)) else $error("fetch in prog");
   main_only_a: assert property (
      fetchRdy_r |-> $past(fetchTarget) == 2'h0) else $error("fetch off main");
   row_fetch_a: assert property (
      rowRdReq_r |-> $past(fetchReq) && rowRdAddr_r == ($past(fetchAddr) >> 3))
      else $error("row addr");
   ecc_gate_a: assert property (
      eccIrq_r |-> eccRegionEn) else $error("irq with ecc off");
   ecc_double_a: assert property (
      eccDouble_r |-> eccIrq_r ##[0:2] fetchFault_r) else $error("double not faulted");
   ee_read_a: assert property (
      eeRdStb |=> eeRdValid_r && eeRdData_r == $past(eeMemData)) else $error("ee read");
   ee_store_a: assert property (
      eeStoreStb |=> eeStoreFault_r) else $error("ee store");
   ee_cmd_a: assert property (
      eeCmdGo |=> eeRowOut) else $error("ee row cmd");
   prot_lock_a: assert property (
      protWrStb && !eraseAllActive |=> protReject_r) else $error("prot not rejected");
endmodule
bind nvm_access nvm_access_chk u_chk (.*);

// ### tb/nvm_flash_model.sv
// far side model: flash row array and eeprom byte array
// assumes requests arrive as the block's one-cycle row read pulses
`timescale 1ns/1ps
module nvm_flash_model (
   // clock and row port
   input wire ref_clk,
   input wire rowRdReq_r,
   input wire [12:0] rowRdAddr_r,
   output reg rowValid,
   output reg [71:0] rowData,
   // test controls: latency, zero data, bit flips
   input wire [1:0] extraWait,
   input wire zeroRow,
   input wire [63:0] flip,
   // eeprom array
   input wire [10:0] eeMemAddr,
   output wire [7:0] eeMemData
);
   reg [2:0] cnt = 3'h0;
   reg [12:0] row = 13'h0;
   reg [63:0] pat;
   integer k;
   initial rowValid = 1'b0;
   initial rowData = 72'h0;
   // byte k of row r holds {r[4:0],k}, i.e. the low address byte
   always @* begin
      for (k = 0; k < 8; k = k + 1)
         pat[8*k +: 8] = {row[4:0], k[2:0]};
   end
   // nine byte row
   // whole row with a zero check byte; bus is scrambled when idle
   always @(posedge ref_clk) begin
      rowValid <= 1'b0;
      rowData <= ~rowData;
      if (cnt != 3'h0)
         cnt <= cnt - 3'h1;
      if (rowRdReq_r) begin
         row <= rowRdAddr_r;
         cnt <= {1'b0, extraWait} + 3'h1;
      end else if (cnt == 3'h1) begin
         rowValid <= 1'b1;
         rowData <= {8'h00, (zeroRow ? 64'h0 : pat) ^ flip};
      end
   end
   assign eeMemData = eeMemAddr[7:0] ^ 8'h5a;
endmodule

// ### tb/tb_top.sv
// self-checking bench for the memory access block
// assumes the far side model and the bound checker are compiled too
`timescale 1ns/1ps
module tb_top;
   reg ref_clk = 1'b0, rstn = 1'b0, porClearN = 1'b0;
   reg [1:0] regAddr = 2'h0, fetchTarget = 2'h0, protWrLevel = 2'h0, extraWait = 2'h0;
   reg [7:0] regWrData = 8'h0, protWrBlock = 8'h0, accBlock = 8'h0, d;
   reg regWrStb = 0, regRdStb = 0, cpuSramReq = 0, dmaSramReq = 0, fetchReq = 0, f;
   reg [12:0] cpuSramAddr = 13'h0, dmaSramAddr = 13'h0;
   reg [15:0] fetchAddr = 16'h0;
   reg progActive = 0, eraseAllActive = 0, protWrStb = 0, accExternal = 0, accWrite = 0;
   reg eeRdStb = 0, eeStoreStb = 0, eeCmdStb = 0, eeCmdErase = 0, eeBusy = 0, zeroRow = 0;
   reg [10:0] eeRdAddr = 11'h0, eeCmdAddr = 11'h0;
   reg [63:0] flip = 64'h0;
   wire [7:0] regRdData_r, fetchData_r, eeMemData, eeRdData_r;
   wire cpuSramGnt, dmaSramGnt, fetchRdy_r, fetchFault_r, rowRdReq_r, rowValid, eccIrq_r;
   wire eccDouble_r, protReject_r, accAllow, eeRdValid_r, eeStoreFault_r, eeRowStb_r;
   wire eeRowErase_r, eeCmdReject_r, resetPinIsExt, jtag5En, jtag4En, swdEn, eccRegionEn;
   wire [12:0] rowRdAddr_r;
   wire [71:0] rowData;
   wire [10:0] eeMemAddr;
   wire [6:0] eeRowIdx_r;
   wire [143:0] pinResetDrive;
   wire [3:0] clkPhaseDelay;
   integer failures = 0, comparisons = 0, i, l, n0, rowReqs = 0, irqs = 0;
   nvm_access i_dut (.*);
   nvm_flash_model i_flash (.*);
   // clock and event counters
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      rowReqs <= rowReqs + rowRdReq_r;
      irqs <= irqs + eccIrq_r;
   end
   task stop_test;
      begin
         if (failures == 0 && comparisons > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   task chk(input [63:0] got, input [63:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // reset: por clear released one edge before rstn
   task rst(input pc);
      begin
         @(posedge ref_clk) rstn <= 1'b0;
         porClearN <= pc;
         repeat (4) @(posedge ref_clk);
         porClearN <= 1'b1;
         @(posedge ref_clk) rstn <= 1'b1;
         @(negedge ref_clk);
      end
   endtask
   task wr(input [1:0] a, input [7:0] v);
      begin
         @(posedge ref_clk) regWrStb <= 1'b1;
         regAddr <= a;
         regWrData <= v;
         @(posedge ref_clk) regWrStb <= 1'b0;
      end
   endtask
   task rd(input [1:0] a, input [7:0] e);
      begin
         @(posedge ref_clk) regRdStb <= 1'b1;
         regAddr <= a;
         @(posedge ref_clk) regRdStb <= 1'b0;
         @(negedge ref_clk) chk(regRdData_r, e);
      end
   endtask
   // fetch; st cycles of programming stall it first
   task fetch(input [1:0] tg, input [15:0] a, input integer st, output [7:0] dv, output fv);
      integer k;
      begin
         @(posedge ref_clk) fetchReq <= 1'b1;
         fetchTarget <= tg;
         fetchAddr <= a;
         progActive <= st > 0;
         for (k = 0; k < st; k = k + 1)
            @(negedge ref_clk) chk(fetchRdy_r | fetchFault_r, 0);
         if (st > 0)
            @(posedge ref_clk) progActive <= 1'b0;
         k = 0;
         do begin
            @(negedge ref_clk);
            k = k + 1;
         end while (k < 30 && fetchRdy_r !== 1'b1 && fetchFault_r !== 1'b1);
         chk(k < 30, 1);
         dv = fetchData_r;
         fv = fetchFault_r;
         @(posedge ref_clk) fetchReq <= 1'b0;
      end
   endtask
   task protwr(input [7:0] b, input [1:0] lv, input rj);
      begin
         @(posedge ref_clk) protWrStb <= 1'b1;
         protWrBlock <= b;
         protWrLevel <= lv;
         @(posedge ref_clk) protWrStb <= 1'b0;
         @(negedge ref_clk) chk(protReject_r, rj);
      end
   endtask
   task acc(input [7:0] b, input [1:0] m, input e);
      begin
         @(posedge ref_clk) {accExternal, accWrite} <= m;
         accBlock <= b;
         @(negedge ref_clk) chk(accAllow, e);
      end
   endtask
   // eeprom command; a busy array must refuse it
   task eecmd(input bz, input [10:0] a, input [6:0] ei);
      begin
         @(posedge ref_clk) eeCmdStb <= 1'b1;
         eeBusy <= bz;
         eeCmdErase <= 1'b1;
         eeCmdAddr <= a;
         @(posedge ref_clk) eeCmdStb <= 1'b0;
         @(negedge ref_clk) chk({eeRowStb_r, eeCmdReject_r, eeRowIdx_r}, {~bz, bz, ei});
         chk(eeRowErase_r, 1);
         @(posedge ref_clk) eeBusy <= 1'b0;
      end
   endtask
   // main sequence
   initial begin
      rst(1'b0);
      for (i = 0; i < 4; i = i + 1)
         rd(i, i == 3);
      chk({jtag5En, jtag4En, swdEn, resetPinIsExt, eccRegionEn, clkPhaseDelay}, 9'h80);
      wr(0, 8'he4);
      wr(1, 8'h40);
      wr(2, 8'hff);
      rd(2, 8'h83);
      for (i = 0; i < 4; i = i + 1) begin
         wr(3, {4'h9, 2'b00, i[1:0]});
         chk({jtag5En, jtag4En, swdEn}, i == 0 ? 3'b010 : 3'b100 >> (i - 1));
         rst(1'b1);
         chk({jtag5En, jtag4En, swdEn}, i == 3 ? 0 : 3'b100 >> i);
      end
      chk({resetPinIsExt, eccRegionEn, clkPhaseDelay}, 6'h29);
      chk(pinResetDrive[63:0], 64'hffffaaaa55550000);
      chk(pinResetDrive[143:80], {16'hffff, 16'h5555, 32'h0});
      // sram: split blocks together, one block takes turns
      @(posedge ref_clk) {cpuSramReq, dmaSramReq} <= 2'b11;
      cpuSramAddr <= 13'h0010;
      dmaSramAddr <= 13'h1010;
      @(negedge ref_clk) chk({cpuSramGnt, dmaSramGnt}, 2'b11);
      @(posedge ref_clk) dmaSramAddr <= 13'h0020;
      @(negedge ref_clk) chk({cpuSramGnt, dmaSramGnt}, 2'b10);
      @(negedge ref_clk) chk({cpuSramGnt, dmaSramGnt}, 2'b01);
      @(posedge ref_clk) {cpuSramReq, dmaSramReq} <= 2'b00;
      // fetch: miss, hit, hit during eeprom write, stalled refetch
      n0 = rowReqs;
      fetch(0, 16'h0123, 0, d, f);
      chk({f, d}, 9'h023);
      fetch(0, 16'h0126, 0, d, f);
      chk({rowReqs - n0, f, d}, {32'h1, 9'h026});
      eeBusy <= 1'b1;
      fetch(0, 16'h0127, 0, d, f);
      chk({f, d}, 9'h027);
      eeBusy <= 1'b0;
      extraWait <= 2'h3;
      fetch(0, 16'h0120, 3, d, f);
      chk({rowReqs - n0, f, d}, {32'h2, 9'h020});
      for (i = 1; i < 4; i = i + 1) begin
         fetch(i, 16'h0120, 0, d, f);
         chk(f, 1);
      end
      extraWait <= 2'h0;
      flip <= 64'h1;
      fetch(0, 16'h0200, 0, d, f);
      chk({irqs, f, d}, {32'h0, 9'h001});
      // eeprom read, direct store, row commands
      @(posedge ref_clk) eeRdStb <= 1'b1;
      eeRdAddr <= 11'h123;
      @(posedge ref_clk) eeRdStb <= 1'b0;
      eeStoreStb <= 1'b1;
      @(negedge ref_clk) chk({eeRdValid_r, eeRdData_r}, 9'h179);
      @(posedge ref_clk) eeStoreStb <= 1'b0;
      @(negedge ref_clk) chk(eeStoreFault_r, 1);
      eecmd(0, 11'h7f5, 7'h7f);
      eecmd(1, 11'h015, 7'h7f);
      // protection: locked outside erase, levels set during erase
      protwr(9, 3, 1);
      acc(9, 2'b10, 1);
      @(posedge ref_clk) eraseAllActive <= 1'b1;
      for (l = 0; l < 4; l = l + 1)
         protwr(l + 1, l, 0);
      @(posedge ref_clk) eraseAllActive <= 1'b0;
      for (l = 0; l < 4; l = l + 1)
         for (i = 0; i < 4; i = i + 1)
            acc(l + 1, i, 16'h13bf >> (l * 4 + i));
      // ecc on: single bit corrected, double bit faulted
      wr(3, 8'h09);
      rst(1'b1);
      chk(eccRegionEn, 1);
      zeroRow <= 1'b1;
      flip <= 64'h100;
      fetch(0, 16'h0301, 0, d, f);
      chk({irqs, f, d}, {32'h1, 9'h000});
      flip <= 64'h3;
      fetch(0, 16'h0408, 0, d, f);
      @(negedge ref_clk) chk({irqs, f}, {32'h2, 1'b1});
      stop_test;
   end
   // watchdog against a hang
   initial begin
      #200000;
      failures = failures + 1;
      stop_test;
   end
endmodule
